// [logic/mws_map.vh]
// Offsets, field positions and reset values of the memory window setup bank
// Notes on behaviour
// - Bit 0 and bits 11:4 of the four window setup registers read as zero; the upper setup register reads back all bits.
// - Placement bits 2:1: 00 anywhere, 01 below 1MB; reset 00.
// - Placement code 10 (64-bit) is accepted only by the third downstream window.
// - Bit 3 marks the window prefetchable; resets to 0.
// - Size bits 30:12 choose which base address bits are writable; bit 31 while setup bit 31 is set; others read zero but bits 3:0 mirror setup bits 3:0.
// - First downstream window reads size 7FFFFh when written all zeros.
// - Size resets to zero, except first downstream window which resets to 7FFFFh.
// - Bit 31 zero disables the base address register, which then reads zero.
// - Enable resets to 0, except first downstream window, which resets enabled.
// - With upper enable set, third window bit 31 becomes a size bit.
// - Upper setup bits 31:0 mask the upper base bits; reset to zero.
// - Upper setup bit 31 enables the 64-bit form; resets to 0.
// - Translated base bits used equal the writable base address bits granted.
`ifndef MWS_MAP_VH
`define MWS_MAP_VH

`define MWS_OFF_DS0       8'hAC
`define MWS_OFF_DS2       8'hB4
`define MWS_OFF_DS3       8'hB8
`define MWS_OFF_DS3_UPPER 8'hBC
`define MWS_OFF_US1       8'hC8

`define MWS_ENABLE_BIT    31
`define MWS_SIZE_HI       30
`define MWS_SIZE_LO       12
`define MWS_PREF_BIT      3
`define MWS_TYPE_HI       2
`define MWS_TYPE_LO       1

`define MWS_TYPE_ANY      2'h0
`define MWS_TYPE_BELOW1M  2'h1
`define MWS_TYPE_64       2'h2

`define MWS_SIZE_4K       19'h7FFFF
`define MWS_DS0_RESET     32'hFFFFF000
`define MWS_OTHER_RESET   32'h00000000
`define MWS_UPPER_RESET   32'h00000000

`define MWS_BAR_UPPER     3'h4

`endif

// [logic/mws_setup_reg.v]
// One memory window setup register with its write filtering
`timescale 1ns/10ps
`default_nettype none
`include "mws_map.vh"

module mws_setup_reg #(
  parameter [31:0] RESET_VAL = 32'h00000000,
  parameter        ALLOW64   = 0,
  parameter        KEEP_MIN  = 0
) (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        wr_i,
  input  wire [31:0] wdata_i,
  output wire [31:0] value_o
);

  reg        en_reg;
  reg [18:0] size_reg;
  reg        pref_reg;
  reg [1:0]  type_reg;
  reg [18:0] size_next;
  reg [1:0]  type_next;

  always @* begin
    size_next = wdata_i[`MWS_SIZE_HI:`MWS_SIZE_LO];
    if (KEEP_MIN != 0 && size_next == 19'h00000)
      size_next = `MWS_SIZE_4K;
    type_next = wdata_i[`MWS_TYPE_HI:`MWS_TYPE_LO];
    if (ALLOW64 == 0)
      type_next[1] = 1'b0;
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_reg   <= RESET_VAL[`MWS_ENABLE_BIT];
      size_reg <= RESET_VAL[`MWS_SIZE_HI:`MWS_SIZE_LO];
      pref_reg <= RESET_VAL[`MWS_PREF_BIT];
      type_reg <= RESET_VAL[`MWS_TYPE_HI:`MWS_TYPE_LO];
    end else if (wr_i) begin
      en_reg   <= wdata_i[`MWS_ENABLE_BIT];
      size_reg <= size_next;
      pref_reg <= wdata_i[`MWS_PREF_BIT];
      type_reg <= type_next;
    end
  end

  assign value_o = {en_reg, size_reg, 8'h00, pref_reg, type_reg, 1'b0};

endmodule // mws_setup_reg
`default_nettype wire

// [logic/mws_bar.v]
// Base address register whose writable bits follow a size mask
`timescale 1ns/10ps
`default_nettype none

module mws_bar (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        wr_i,
  input  wire [31:0] wdata_i,
  input  wire        en_i,
  input  wire [31:0] mask_i,
  input  wire [3:0]  low_i,
  output wire [31:0] rdata_o
);

  reg [31:0] base_reg;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      base_reg <= 32'h00000000;
    else if (wr_i && en_i)
      base_reg <= wdata_i & mask_i;
  end

  // Masking on read too, so a later smaller size hides stale bits
  assign rdata_o = en_i ? ((base_reg & mask_i) | {28'h0000000, low_i})
                        : 32'h00000000;

endmodule // mws_bar
`default_nettype wire

// [logic/mws_regs.v]
// Memory window setup register bank with its five base address registers
`timescale 1ns/10ps
`default_nettype none
`include "mws_map.vh"

module mws_regs (
  input  wire        clk_i,
  input  wire        reset_n_i,
  // Preload / local processor setup path
  input  wire        setup_wr_i,
  input  wire [7:0]  setup_addr_i,
  input  wire [31:0] setup_wdata_i,
  // Host configuration access to the setup registers
  input  wire        host_rd_i,
  input  wire        host_wr_i,
  input  wire [7:0]  host_addr_i,
  output reg  [31:0] host_rdata_o,
  output reg         host_ack_o,
  // Host access to the base address registers
  input  wire        bar_rd_i,
  input  wire        bar_wr_i,
  input  wire [2:0]  bar_sel_i,
  input  wire [31:0] bar_wdata_i,
  output reg  [31:0] bar_rdata_o,
  output reg         bar_ack_o,
  // Window state toward the decoder and translator
  output reg  [3:0]  win_en_o,
  output reg         win64_en_o,
  output reg  [3:0]  win_prefetch_o,
  output reg  [7:0]  win_type_o,
  output reg  [79:0] xlat_mask_o,
  output reg  [31:0] xlat_hi_mask_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Window index of an offset; 3'h4 upper setup, 3'h7 unmapped
  function [2:0] mws_sel;
    input [7:0] addr;
    begin
      case (addr)
        `MWS_OFF_DS0:       mws_sel = 3'h0;
        `MWS_OFF_DS2:       mws_sel = 3'h1;
        `MWS_OFF_DS3:       mws_sel = 3'h2;
        `MWS_OFF_US1:       mws_sel = 3'h3;
        `MWS_OFF_DS3_UPPER: mws_sel = 3'h4;
        default:            mws_sel = 3'h7;
      endcase
    end
  endfunction

  wire [2:0] setup_sel = mws_sel(setup_addr_i);
  wire [2:0] host_sel  = mws_sel(host_addr_i);

  ////////////////////////////////////////////////////////////////////////////
  // Upper half setup of the third downstream window

  reg [31:0] upper_reg;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      upper_reg <= `MWS_UPPER_RESET;
    else if (setup_wr_i && setup_sel == 3'h4)
      upper_reg <= setup_wdata_i;
  end

  // Mask is taken as loaded; placement 10 is the agent's duty
  wire        up64      = upper_reg[`MWS_ENABLE_BIT];
  wire [31:0] hi_mask   = up64 ? upper_reg : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Setup registers and base address registers per window

  wire [31:0] setup_val [0:3];
  wire [31:0] bar_val   [0:3];
  wire [3:0]  win_en;
  wire [79:0] win_mask;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_win
      mws_setup_reg #(
        .RESET_VAL ((i == 0) ? `MWS_DS0_RESET : `MWS_OTHER_RESET),
        .ALLOW64   ((i == 2) ? 1 : 0),
        .KEEP_MIN  ((i == 0) ? 1 : 0)
      ) u_setup (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .wr_i      (setup_wr_i && setup_sel == i),
        .wdata_i   (setup_wdata_i),
        .value_o   (setup_val[i])
      );

      // Third window: upper enable turns bit 31 into a size bit
      if (i == 2) begin : g_w64
        assign win_en[i] = up64 | setup_val[i][`MWS_ENABLE_BIT];
      end else begin : g_w32
        assign win_en[i] = setup_val[i][`MWS_ENABLE_BIT];
      end

      // Bit 31 writable only when setup bit 31 is set, as enable or as size bit
      assign win_mask[i*20 +: 20] = win_en[i] ?
             setup_val[i][31:12] : 20'h00000;

      mws_bar u_bar (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .wr_i      (bar_wr_i && bar_sel_i == i),
        .wdata_i   (bar_wdata_i),
        .en_i      (win_en[i]),
        .mask_i    ({win_mask[i*20 +: 20], 12'h000}),
        .low_i     (setup_val[i][3:0]),
        .rdata_o   (bar_val[i])
      );
    end
  endgenerate

  wire [31:0] bar_hi_val;

  mws_bar u_bar_hi (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (bar_wr_i && bar_sel_i == `MWS_BAR_UPPER),
    .wdata_i   (bar_wdata_i),
    .en_i      (up64),
    .mask_i    (hi_mask),
    .low_i     (4'h0),
    .rdata_o   (bar_hi_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host read of the setup registers; host writes are ignored

  reg [31:0] host_rdata_next;

  always @* begin
    case (host_sel)
      3'h0:    host_rdata_next = setup_val[0];
      3'h1:    host_rdata_next = setup_val[1];
      3'h2:    host_rdata_next = setup_val[2];
      3'h3:    host_rdata_next = setup_val[3];
      3'h4:    host_rdata_next = upper_reg;
      default: host_rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_rdata_o <= 32'h00000000;
      host_ack_o   <= 1'b0;
    end else begin
      host_ack_o <= host_rd_i | host_wr_i;
      if (host_rd_i)
        host_rdata_o <= host_rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host read of the base address registers

  reg [31:0] bar_rdata_next;

  always @* begin
    case (bar_sel_i)
      3'h0:    bar_rdata_next = bar_val[0];
      3'h1:    bar_rdata_next = bar_val[1];
      3'h2:    bar_rdata_next = bar_val[2];
      3'h3:    bar_rdata_next = bar_val[3];
      3'h4:    bar_rdata_next = bar_hi_val;
      default: bar_rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bar_rdata_o <= 32'h00000000;
      bar_ack_o   <= 1'b0;
    end else begin
      bar_ack_o <= bar_rd_i | bar_wr_i;
      if (bar_rd_i)
        bar_rdata_o <= bar_rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered window state for the decoder and translator

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_en_o       <= 4'h0;
      win64_en_o     <= 1'b0;
      win_prefetch_o <= 4'h0;
      win_type_o     <= 8'h00;
      xlat_mask_o    <= {80{1'b0}};
      xlat_hi_mask_o <= 32'h00000000;
    end else begin
      win_en_o       <= win_en;
      win64_en_o     <= up64;
      win_prefetch_o <= {setup_val[3][`MWS_PREF_BIT],
                         setup_val[2][`MWS_PREF_BIT],
                         setup_val[1][`MWS_PREF_BIT],
                         setup_val[0][`MWS_PREF_BIT]};
      win_type_o     <= {setup_val[3][2:1], setup_val[2][2:1],
                         setup_val[1][2:1], setup_val[0][2:1]};
      xlat_mask_o    <= win_mask;
      xlat_hi_mask_o <= hi_mask;
    end
  end

endmodule // mws_regs
`default_nettype wire

// [sim/mws_regs_checker.sv]
// Assertion checker for the memory window setup bank
`timescale 1ns/10ps
`default_nettype none
module mws_regs_checker (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        setup_wr_i,
  input wire logic [7:0]  setup_addr_i,
  input wire logic [31:0] setup_wdata_i,
  input wire logic        host_rd_i,
  input wire logic        host_wr_i,
  input wire logic [7:0]  host_addr_i,
  input wire logic [31:0] host_rdata_o,
  input wire logic        host_ack_o,
  input wire logic        bar_rd_i,
  input wire logic        bar_wr_i,
  input wire logic [2:0]  bar_sel_i,
  input wire logic [31:0] bar_rdata_o,
  input wire logic        bar_ack_o,
  input wire logic [3:0]  win_en_o,
  input wire logic        win64_en_o,
  input wire logic [7:0]  win_type_o,
  input wire logic [79:0] xlat_mask_o,
  input wire logic [31:0] xlat_hi_mask_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  host_ack_a: assert property (host_rd_i |=> host_ack_o)
    else $error("host ack missing");
  ack_idle_a: assert property (!(host_rd_i || host_wr_i) |=> !host_ack_o)
    else $error("host ack without request");
  low_zero_a: assert property (host_ack_o && $past(host_rd_i) &&
    $past(host_addr_i) != 8'hBC |-> host_rdata_o[11:4] == 8'h00 &&
    !host_rdata_o[0]) else $error("reserved setup bits set");
  size_4k_a: assert property (host_ack_o && $past(host_rd_i) &&
    $past(host_addr_i) == 8'hAC |-> host_rdata_o[30:12] != 19'h00000)
    else $error("first window size reads zero");
  bar_low_a: assert property (bar_ack_o && $past(bar_rd_i) &&
    $past(bar_sel_i) < 3'h4 |-> bar_rdata_o[11:4] == 8'h00)
    else $error("base low bits not zero");
  hi_mask_a: assert property (!win64_en_o |-> xlat_hi_mask_o == 32'h0)
    else $error("upper mask without 64-bit form");
  type_code_a: assert property (!win_type_o[1] && !win_type_o[3] &&
    !win_type_o[7]) else $error("64-bit code outside third window");
  en_follow_a: assert property ((setup_wr_i && setup_addr_i == 8'hB4)
    ##1 !(setup_wr_i && setup_addr_i == 8'hB4)
    |=> win_en_o[1] == $past(setup_wdata_i[31], 2))
    else $error("enable does not follow setup write");
  for (genvar w = 0; w < 4; w++) begin : g_off
    off_mask_a: assert property (!win_en_o[w] |->
      xlat_mask_o[20*w +: 20] == 20'h0) else $error("mask while disabled");
  end
  cover property (host_rd_i && host_addr_i == 8'hAC);
  cover property ($rose(win64_en_o));
  cover property (bar_wr_i && bar_sel_i == 3'h4);
endmodule // mws_regs_checker
bind mws_regs mws_regs_checker chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .setup_wr_i(setup_wr_i), .setup_addr_i(setup_addr_i),
  .setup_wdata_i(setup_wdata_i), .host_rd_i(host_rd_i),
  .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
  .host_rdata_o(host_rdata_o), .host_ack_o(host_ack_o),
  .bar_rd_i(bar_rd_i), .bar_wr_i(bar_wr_i), .bar_sel_i(bar_sel_i),
  .bar_rdata_o(bar_rdata_o), .bar_ack_o(bar_ack_o), .win_en_o(win_en_o),
  .win64_en_o(win64_en_o), .win_type_o(win_type_o),
  .xlat_mask_o(xlat_mask_o), .xlat_hi_mask_o(xlat_hi_mask_o));
`default_nettype wire

// [sim/mws_setup_agent.sv]
// Preload and local processor setup path model
`timescale 1ns/10ps
`default_nettype none
module mws_setup_agent (
  input  wire logic   clk_i,
  output logic        setup_wr_o,
  output logic [7:0]  setup_addr_o,
  output logic [31:0] setup_wdata_o
);
  initial begin
    setup_wr_o = 1'b0;
    setup_addr_o = 8'h00;
    setup_wdata_o = 32'h0;
  end
  // Whole word per load; stale lines go inverted afterwards
  task automatic load(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    setup_wr_o <= 1'b1;
    setup_addr_o <= a;
    setup_wdata_o <= d;
    @(posedge clk_i);
    setup_wr_o <= 1'b0;
    setup_addr_o <= ~a;
    setup_wdata_o <= ~d;
  endtask
endmodule // mws_setup_agent
`default_nettype wire

// [sim/mws_regs_tb.sv]
// Self-checking bench for the memory window setup bank
`timescale 1ns/10ps
`default_nettype none
module mws_regs_tb;
  logic clk_i, reset_n_i, host_rd_i, host_wr_i, bar_rd_i, bar_wr_i;
  logic [7:0]  host_addr_i;
  logic [2:0]  bar_sel_i;
  logic [31:0] bar_wdata_i, d, s, w;
  wire         setup_wr_i, host_ack_o, bar_ack_o, win64_en_o;
  wire [7:0]   setup_addr_i, win_type_o;
  wire [31:0]  setup_wdata_i, host_rdata_o, bar_rdata_o, xlat_hi_mask_o;
  wire [3:0]   win_en_o, win_prefetch_o;
  wire [79:0]  xlat_mask_o;
  logic [7:0]  offs [0:3] = '{8'hAC, 8'hB4, 8'hB8, 8'hC8};
  logic [31:0] cd [0:2] = '{32'h0, 32'hFFFFFFFF, 32'h8000F004};
  integer error_cnt = 0, comparisons = 0, seed = 37, cyc = 0, k;
  logic [1:0]  i;
  mws_setup_agent agent_u (.clk_i(clk_i), .setup_wr_o(setup_wr_i),
    .setup_addr_o(setup_addr_i), .setup_wdata_o(setup_wdata_i));
  mws_regs dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .setup_wr_i(setup_wr_i), .setup_addr_i(setup_addr_i),
    .setup_wdata_i(setup_wdata_i), .host_rd_i(host_rd_i),
    .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
    .host_rdata_o(host_rdata_o), .host_ack_o(host_ack_o),
    .bar_rd_i(bar_rd_i), .bar_wr_i(bar_wr_i), .bar_sel_i(bar_sel_i),
    .bar_wdata_i(bar_wdata_i), .bar_rdata_o(bar_rdata_o),
    .bar_ack_o(bar_ack_o), .win_en_o(win_en_o), .win64_en_o(win64_en_o),
    .win_prefetch_o(win_prefetch_o), .win_type_o(win_type_o),
    .xlat_mask_o(xlat_mask_o), .xlat_hi_mask_o(xlat_hi_mask_o));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  function automatic [31:0] exp_set(input [1:0] n, input [31:0] v);
    logic [31:0] r;
    r = v & 32'hFFFFF00E;
    if (n != 2'd2) r[2] = 1'b0;
    if (n == 2'd0 && r[30:12] == 19'h0) r[30:12] = 19'h7FFFF;
    return r;
  endfunction
  function automatic [31:0] exp_bar(input [31:0] r, input [31:0] v);
    return r[31] ? (v & {r[31:12], 12'h000}) | {28'h0, r[3:0]} : 32'h0;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hrd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    host_rd_i <= 1'b1;
    host_addr_i <= a;
    @(posedge clk_i);
    host_rd_i <= 1'b0;
    #1 chk(host_ack_o, 1);
    chk(host_rdata_o, e);
  endtask
  task automatic bacc(input logic wr, input logic [2:0] n,
                      input logic [31:0] v, input logic [31:0] e);
    @(posedge clk_i);
    bar_wr_i <= wr;
    bar_rd_i <= !wr;
    bar_sel_i <= n;
    bar_wdata_i <= v;
    @(posedge clk_i);
    bar_wr_i <= 1'b0;
    bar_rd_i <= 1'b0;
    bar_wdata_i <= ~v;
    #1 chk(bar_ack_o, 1);
    if (!wr) chk(bar_rdata_o, e);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////
  initial begin
    {reset_n_i, host_rd_i, host_wr_i, bar_rd_i, bar_wr_i} = 5'h00;
    host_addr_i = 8'h00;
    bar_sel_i = 3'h0;
    bar_wdata_i = 32'h0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    hrd(8'hAC, 32'hFFFFF000);
    for (k = 1; k < 4; k++) hrd(offs[k], 32'h0);
    hrd(8'hBC, 32'h0);
    hrd(8'hB0, 32'h0);
    chk(win_en_o, 4'h1);
    bacc(1'b1, 3'h0, 32'hFFFFFFFF, 32'h0);
    bacc(1'b0, 3'h0, 32'h0, 32'hFFFFF000);
    @(posedge clk_i);
    host_wr_i <= 1'b1;
    host_addr_i <= 8'hAC;
    @(posedge clk_i);
    host_wr_i <= 1'b0;
    #1 chk(host_ack_o, 1);
    hrd(8'hAC, 32'hFFFFF000);
    for (k = 0; k < 16; k++) begin
      i = k[1:0];
      d = (k < 3) ? cd[k] : $random(seed);
      w = $random(seed);
      s = exp_set(i, d);
      agent_u.load(offs[i], d);
      hrd(offs[i], s);
      bacc(1'b1, {1'b0, i}, w, 32'h0);
      bacc(1'b0, {1'b0, i}, 32'h0, exp_bar(s, w));
      chk(win_en_o[i], s[31]);
      chk(xlat_mask_o[20*i +: 20], s[31] ? s[31:12] : 20'h0);
      chk(win_prefetch_o[i], s[3]);
      chk(win_type_o[2*i +: 2], s[2:1]);
    end
    // Placement 10 goes in before the upper mask
    agent_u.load(8'hB8, 32'h00100004);
    agent_u.load(8'hBC, 32'h8000000F);
    hrd(8'hBC, 32'h8000000F);
    bacc(1'b1, 3'h4, 32'hFFFFFFFF, 32'h0);
    bacc(1'b0, 3'h4, 32'h0, 32'h8000000F);
    bacc(1'b1, 3'h2, 32'hFFFFFFFF, 32'h0);
    bacc(1'b0, 3'h2, 32'h0, 32'h00100004);
    chk(win64_en_o, 1'b1);
    chk(xlat_hi_mask_o, 32'h8000000F);
    // Bit 31 of the third window as a size bit in the 64-bit form
    agent_u.load(8'hB8, 32'h80100004);
    bacc(1'b1, 3'h2, 32'hFFFFFFFF, 32'h0);
    bacc(1'b0, 3'h2, 32'h0, 32'h80100004);
    chk(xlat_mask_o[59:40], 20'h80100);
    agent_u.load(8'hBC, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk(win64_en_o, 1'b0);
    chk(xlat_hi_mask_o, 32'h0);
    bacc(1'b0, 3'h2, 32'h0, 32'h80100004);
    agent_u.load(8'hB8, 32'h0);
    bacc(1'b0, 3'h2, 32'h0, 32'h0);
    tally_and_finish;
  end
endmodule // mws_regs_tb
`default_nettype wire
